// ===== shared/sdcr_pkg.sv
// Purpose: shared constants and types of the sound demodulator config registers
// Assumes: one 8-bit subaddress space, byte writes from the i2c slave front end
// Notes: field positions are bit indices within each register byte
package sdcr_pkg;
   // subaddresses
   localparam logic [7:0] SA_MON_SEL = 8'h02;
   localparam logic [7:0] SA_C1_HI = 8'h03;
   localparam logic [7:0] SA_C1_LO = 8'h05;
   localparam logic [7:0] SA_C2_HI = 8'h06;
   localparam logic [7:0] SA_C2_LO = 8'h08;
   localparam logic [7:0] SA_DCONF = 8'h09;
   // byte position within a frequency word, high byte first
   localparam logic [1:0] IDX_HI = 2'h0;
   localparam logic [1:0] IDX_MID = 2'h1;
   localparam logic [1:0] IDX_LO = 2'h2;
   // reset values
   localparam logic [7:0] MON_SEL_RESET = 8'h00;
   localparam logic [7:0] DCONF_RESET = 8'h00;
   localparam logic [23:0] FREQ_RESET = 24'h000000;
   // monitor select fields
   localparam int MON_PEAK_BIT = 7;
   localparam int MON_CH_LSB = 3;
   localparam int MON_SRC_LSB = 0;
   // demodulator config fields
   localparam int DC_ID_LSB = 6;
   localparam int DC_AREA_BIT = 5;
   localparam int DC_FBW_HI_BIT = 4;
   localparam int DC_CH2_LSB = 2;
   localparam int DC_FBW_LO_BIT = 1;
   localparam int DC_CH1_BIT = 0;
   // clock rates in khz; mixer step per tick is word / 2**FREQ_BITS
   localparam logic [16:0] REF_CLK_KHZ = 17'h09c40;
   localparam logic [16:0] MIX_CLK_KHZ = 17'h03000;
   localparam int FREQ_BITS = 24;
   // field codes
   typedef enum logic [1:0] {SRC_DC, SRC_MAGPH, SRC_PATH, SRC_NICAM} sdcr_src_e;
   typedef enum logic [1:0] {CHAN_AVG, CHAN_ONE, CHAN_TWO, CHAN_RSVD} sdcr_chan_e;
   typedef enum logic [1:0] {CH2_FM, CH2_AM, CH2_NICAM, CH2_RSVD} sdcr_ch2_e;
   typedef enum logic [1:0] {ID_SLOW, ID_MEDIUM, ID_FAST, ID_OFF} sdcr_ident_e;
   typedef enum logic [1:0] {FBW_NARROW, FBW_XWIDE, FBW_MEDIUM, FBW_WIDE} sdcr_fbw_e;
endpackage

// ===== core/sdcr_freq_word.sv
// Purpose: one 24-bit carrier frequency word with staged bytes and a phase accumulator
// Assumes: bytes arrive high, mid, low within one transfer
// Notes: the live word only changes on the low byte of a complete set
module sdcr_freq_word
   import sdcr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // byte writes
   input wire logic wr_en,
   input wire logic [1:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic xfer_end,
   // mixer rate enable
   input wire logic mix_tick,
   // results
   output logic [23:0] word_q,
   output logic [23:0] phase_q
);
   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] mid;
      logic got_hi;
      logic got_mid;
      logic [23:0] word;
      logic [23:0] phase;
   } sdcr_fw_s;
   sdcr_fw_s q, d;

   // staging and commit; partial sets never reach the mixer
   always_comb begin
      d = q;
      if (mix_tick) begin
         d.phase = q.phase + q.word;
      end
      if (wr_en) begin
         if (wr_idx == IDX_HI) begin
            d.hi = wr_data;
            d.got_hi = 1'b1;
            d.got_mid = 1'b0;
         end else if (wr_idx == IDX_MID) begin
            d.mid = wr_data;
            d.got_mid = q.got_hi;
         end else if (wr_idx == IDX_LO) begin
            if (q.got_hi && q.got_mid) begin
               d.word = {q.hi, q.mid, wr_data};
            end
            d.got_hi = 1'b0;
            d.got_mid = 1'b0;
         end
      end
      // early stop drops whatever was staged
      if (xfer_end) begin
         d.got_hi = 1'b0;
         d.got_mid = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.word <= FREQ_RESET;
      end else begin
         q <= d;
      end
   end

   assign word_q = q.word;
   assign phase_q = q.phase;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_word_commit: assert property (
      wr_en && wr_idx == IDX_LO && q.got_hi && q.got_mid
      |=> word_q == {$past(q.hi), $past(q.mid), $past(wr_data)})
      else $error("complete byte set not applied");
   a_partial_drop: assert property (
      !(wr_en && wr_idx == IDX_LO && q.got_hi && q.got_mid) |=> $stable(word_q))
      else $error("word changed without complete byte set");
   a_phase_step: assert property (
      mix_tick |=> phase_q == 24'($past(phase_q) + $past(word_q)))
      else $error("phase step differs from word");
endmodule

// ===== core/sdcr_monitor.sv
// Purpose: monitor tap selection, channel combination, last sample and peak capture
// Assumes: all taps share one sample strobe
// Notes: peak is a rectified magnitude, cleared after each read-out
module sdcr_monitor
   import sdcr_pkg::*;
#(
   parameter int SW = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // selection
   input wire logic [7:0] sel,
   input wire logic ch1_am,
   input wire logic ch2_am,
   // taps
   input wire logic samp_valid,
   input wire logic signed [SW-1:0] dc1,
   input wire logic signed [SW-1:0] dc2,
   input wire logic signed [SW-1:0] ph1,
   input wire logic signed [SW-1:0] ph2,
   input wire logic signed [SW-1:0] mag1,
   input wire logic signed [SW-1:0] mag2,
   input wire logic signed [SW-1:0] path1,
   input wire logic signed [SW-1:0] path2,
   input wire logic signed [SW-1:0] nicam1,
   input wire logic signed [SW-1:0] nicam2,
   // read-out
   input wire logic read_done,
   output logic [SW-1:0] mon_q
);
   if (SW < 4) begin : g_bad_width
      $error("sample width too small");
   end

   typedef struct packed {
      logic [SW-1:0] last;
      logic [SW-1:0] peak;
      logic [SW-1:0] out;
   } sdcr_mon_s;
   sdcr_mon_s q, d;
   logic signed [SW-1:0] t1, t2, v;
   logic signed [SW:0] sum;
   logic [SW-1:0] mag;

   // tap choice; magnitude in am, differentiated phase in fm
   always_comb begin
      case (sdcr_src_e'(sel[MON_SRC_LSB+:2]))
         SRC_DC: begin
            t1 = dc1;
            t2 = dc2;
         end
         SRC_MAGPH: begin
            t1 = ch1_am ? mag1 : ph1;
            t2 = ch2_am ? mag2 : ph2;
         end
         SRC_PATH: begin
            t1 = path1;
            t2 = path2;
         end
         default: begin
            t1 = nicam1;
            t2 = nicam2;
         end
      endcase
      sum = {t1[SW-1], t1} + {t2[SW-1], t2};
      case (sdcr_chan_e'(sel[MON_CH_LSB+:2]))
         CHAN_AVG: v = sum[SW:1];
         CHAN_ONE: v = t1;
         default: v = t2;
      endcase
      mag = v[SW-1] ? (~v + 1'b1) : v;
   end

   // capture; a sample in the clearing cycle seeds the new peak
   always_comb begin
      d = q;
      if (read_done) begin
         d.peak = '0;
      end
      if (samp_valid) begin
         d.last = v;
         if (mag > d.peak) begin
            d.peak = mag;
         end
      end
      d.out = sel[MON_PEAK_BIT] ? d.peak : d.last;
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign mon_q = q.out;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_peak_clear: assert property (
      read_done && !samp_valid |=> q.peak == '0)
      else $error("peak not cleared after read-out");
   a_last_sample: assert property (
      samp_valid && !sel[MON_PEAK_BIT] |=> mon_q == $past(v))
      else $error("last sample not presented");
   a_peak_hold: assert property (
      !read_done && !samp_valid |=> q.peak == $past(q.peak))
      else $error("peak moved without a sample");
endmodule

// ===== core/sdcr_regs.sv
// Purpose: write-side control registers of the tv sound demodulator, subaddresses 2 to 9
// Assumes: an i2c slave front end delivers byte writes and transfer-end pulses
// Notes: registers are write only; the monitor value is the read-back path
module sdcr_regs
   import sdcr_pkg::*;
#(
   parameter int SW = 16
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // byte write port from the i2c slave
   input wire logic reg_wr,
   input wire logic [7:0] reg_subaddr,
   input wire logic [7:0] reg_wdata,
   input wire logic xfer_end,
   // monitor read-out done pulse from the i2c slave
   input wire logic mon_read_done,
   // demodulator taps
   input wire logic samp_valid,
   input wire logic signed [SW-1:0] dc1,
   input wire logic signed [SW-1:0] dc2,
   input wire logic signed [SW-1:0] ph1,
   input wire logic signed [SW-1:0] ph2,
   input wire logic signed [SW-1:0] mag1,
   input wire logic signed [SW-1:0] mag2,
   input wire logic signed [SW-1:0] path1,
   input wire logic signed [SW-1:0] path2,
   input wire logic signed [SW-1:0] nicam1,
   input wire logic signed [SW-1:0] nicam2,
   // register images
   output logic [7:0] monitor_select,
   output logic [7:0] demod_config,
   // decoded configuration
   output logic [1:0] ident_speed,
   output logic ident_region,
   output logic ident_reset,
   output logic [1:0] filter_width,
   output logic [1:0] second_carrier_mode,
   output logic first_carrier_am_select,
   // mixer control
   output logic mix_tick,
   output logic [23:0] carrier_one_freq,
   output logic [23:0] carrier_two_freq,
   output logic [23:0] carrier_one_phase,
   output logic [23:0] carrier_two_phase,
   // monitor read-back
   output logic [SW-1:0] mon_value
);
   if (MIX_CLK_KHZ >= REF_CLK_KHZ) begin : g_bad_rate
      $error("mixer rate must be below the reference clock");
   end
   // the monitor's averaging and magnitude need a few bits of headroom
   if (SW < 4) begin : g_bad_sw
      $error("sample width too small for the monitor");
   end

   typedef struct packed {
      logic [7:0] mon_sel;
      logic [7:0] dconf;
      logic ident_rst;
      logic [16:0] frac;
      logic tick;
   } sdcr_top_s;
   sdcr_top_s q, d;

   logic rst_meta_q, rst_n_q;
   logic c1_wr, c2_wr;
   logic [1:0] c1_idx, c2_idx;
   logic [16:0] frac_sum;

   // reset release through two flops; assertion stays asynchronous
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // frequency byte routing by subaddress range
   always_comb begin
      c1_wr = 1'b0;
      c2_wr = 1'b0;
      c1_idx = 2'(reg_subaddr - SA_C1_HI);
      c2_idx = 2'(reg_subaddr - SA_C2_HI);
      if (reg_wr && reg_subaddr >= SA_C1_HI && reg_subaddr <= SA_C1_LO) begin
         c1_wr = 1'b1;
      end else if (reg_wr && reg_subaddr >= SA_C2_HI && reg_subaddr <= SA_C2_LO) begin
         c2_wr = 1'b1;
      end
   end

   // byte registers and fractional mixer-rate divider
   always_comb begin
      d = q;
      // unused subaddresses are ignored; no reply needed on a write-only map
      if (reg_wr && reg_subaddr == SA_MON_SEL) begin
         d.mon_sel = reg_wdata;
      end else if (reg_wr && reg_subaddr == SA_DCONF) begin
         d.dconf = reg_wdata;
      end
      d.ident_rst = (d.dconf[DC_ID_LSB+:2] == ID_OFF);
      // 40 mhz to 12.288 mhz average rate, jitter of one reference cycle
      frac_sum = q.frac + MIX_CLK_KHZ;
      if (frac_sum >= REF_CLK_KHZ) begin
         d.frac = frac_sum - REF_CLK_KHZ;
         d.tick = 1'b1;
      end else begin
         d.frac = frac_sum;
         d.tick = 1'b0;
      end
   end

   // state register
   always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         q <= '0;
         q.mon_sel <= MON_SEL_RESET;
         q.dconf <= DCONF_RESET;
      end else begin
         q <= d;
      end
   end

   // outputs are slices of the state flops
   assign monitor_select = q.mon_sel;
   assign demod_config = q.dconf;
   assign ident_speed = q.dconf[DC_ID_LSB+:2];
   assign ident_region = q.dconf[DC_AREA_BIT];
   assign ident_reset = q.ident_rst;
   assign filter_width = {q.dconf[DC_FBW_HI_BIT], q.dconf[DC_FBW_LO_BIT]};
   assign second_carrier_mode = q.dconf[DC_CH2_LSB+:2];
   assign first_carrier_am_select = q.dconf[DC_CH1_BIT];
   assign mix_tick = q.tick;

   // first sound carrier
   sdcr_freq_word u_carrier_one (
      .clk(ref_clk),
      .rst_n(rst_n_q),
      .wr_en(c1_wr),
      .wr_idx(c1_idx),
      .wr_data(reg_wdata),
      .xfer_end(xfer_end),
      .mix_tick(q.tick),
      .word_q(carrier_one_freq),
      .phase_q(carrier_one_phase)
   );

   // second fm carrier or nicam carrier, same format
   sdcr_freq_word u_carrier_two (
      .clk(ref_clk),
      .rst_n(rst_n_q),
      .wr_en(c2_wr),
      .wr_idx(c2_idx),
      .wr_data(reg_wdata),
      .xfer_end(xfer_end),
      .mix_tick(q.tick),
      .word_q(carrier_two_freq),
      .phase_q(carrier_two_phase)
   );

   // monitor tap; first peak after a source change may be stale
   sdcr_monitor #(
      .SW(SW)
   ) u_monitor (
      .clk(ref_clk),
      .rst_n(rst_n_q),
      .sel(q.mon_sel),
      .ch1_am(q.dconf[DC_CH1_BIT]),
      .ch2_am(q.dconf[DC_CH2_LSB+:2] == CH2_AM),
      .samp_valid(samp_valid),
      .dc1(dc1),
      .dc2(dc2),
      .ph1(ph1),
      .ph2(ph2),
      .mag1(mag1),
      .mag2(mag2),
      .path1(path1),
      .path2(path2),
      .nicam1(nicam1),
      .nicam2(nicam2),
      .read_done(mon_read_done),
      .mon_q(mon_value)
   );

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n_q);

   a_mon_sel_write: assert property (
      reg_wr && reg_subaddr == SA_MON_SEL |=> monitor_select == $past(reg_wdata))
      else $error("monitor select not written");
   a_dconf_write: assert property (
      reg_wr && reg_subaddr == SA_DCONF |=> demod_config == $past(reg_wdata))
      else $error("demodulator config not written");
   a_cfg_hold: assert property (
      !(reg_wr && (reg_subaddr == SA_MON_SEL || reg_subaddr == SA_DCONF))
      |=> $stable(monitor_select) && $stable(demod_config))
      else $error("config changed without a write");
   a_ident_off: assert property (
      reg_wr && reg_subaddr == SA_DCONF |=> ident_reset == ($past(reg_wdata[7:6]) == 2'h3))
      else $error("ident reset not following mode 11");
   a_tick_spacing: assert property (
      mix_tick |=> !mix_tick ##1 1'b1)
      else $error("mixer ticks back to back");
   // ticks fall 3 or 4 cycles apart; counted from a tick so the slow first one is not judged
   a_tick_present: assert property (
      mix_tick |-> ##[3:4] mix_tick)
      else $error("mixer tick missing");
   a_c1_route: assert property (
      reg_wr && reg_subaddr == SA_C1_HI |-> c1_wr && c1_idx == IDX_HI && !c2_wr)
      else $error("high byte of first carrier misrouted");
   a_c2_route: assert property (
      reg_wr && reg_subaddr == SA_C2_LO |-> c2_wr && c2_idx == IDX_LO && !c1_wr)
      else $error("low byte of second carrier misrouted");
   a_c1_mid_route: assert property (
      reg_wr && reg_subaddr == SA_C1_HI + 8'h01 |-> c1_wr && c1_idx == IDX_MID && !c2_wr)
      else $error("middle byte of first carrier misrouted");
   a_c1_lo_route: assert property (
      reg_wr && reg_subaddr == SA_C1_LO |-> c1_wr && c1_idx == IDX_LO && !c2_wr)
      else $error("low byte of first carrier misrouted");
   a_c2_hi_route: assert property (
      reg_wr && reg_subaddr == SA_C2_HI |-> c2_wr && c2_idx == IDX_HI && !c1_wr)
      else $error("high byte of second carrier misrouted");
   a_c2_mid_route: assert property (
      reg_wr && reg_subaddr == SA_C2_HI + 8'h01 |-> c2_wr && c2_idx == IDX_MID && !c1_wr)
      else $error("middle byte of second carrier misrouted");
   // bytes outside 3 to 8 must never reach a staging register
   a_unmapped_quiet: assert property (
      reg_subaddr < SA_C1_HI || reg_subaddr > SA_C2_LO |-> !c1_wr && !c2_wr)
      else $error("frequency byte taken at an unmapped subaddress");

   // live words move only on a byte write to their own range, never on a bare stop
   a_word_one_keep: assert property (
      !c1_wr |=> $stable(carrier_one_freq))
      else $error("first carrier word moved without a byte write");
   a_word_two_keep: assert property (
      !c2_wr |=> $stable(carrier_two_freq))
      else $error("second carrier word moved without a byte write");
   a_stop_no_commit: assert property (
      xfer_end && !reg_wr |=> $stable(carrier_one_freq) && $stable(carrier_two_freq))
      else $error("stop alone changed a carrier word");

   // a write elsewhere leaves the other register image alone
   a_sel_map_hold: assert property (
      reg_wr && reg_subaddr != SA_MON_SEL |=> $stable(monitor_select))
      else $error("monitor select changed by another subaddress");
   a_dconf_map_hold: assert property (
      reg_wr && reg_subaddr != SA_DCONF |=> $stable(demod_config))
      else $error("demodulator config changed by another subaddress");

   // decoded fields follow the byte just written
   a_speed_field: assert property (
      reg_wr && reg_subaddr == SA_DCONF |=> ident_speed == $past(reg_wdata[7:6]))
      else $error("ident speed field wrong");
   a_region_field: assert property (
      reg_wr && reg_subaddr == SA_DCONF |=> ident_region == $past(reg_wdata[5]))
      else $error("ident region field wrong");
   a_width_field: assert property (
      reg_wr && reg_subaddr == SA_DCONF |=> filter_width == {$past(reg_wdata[4]), $past(reg_wdata[1])})
      else $error("filter width field wrong");
   a_ch2_field: assert property (
      reg_wr && reg_subaddr == SA_DCONF |=> second_carrier_mode == $past(reg_wdata[3:2]))
      else $error("second carrier mode field wrong");
   a_ch1_field: assert property (
      reg_wr && reg_subaddr == SA_DCONF |=> first_carrier_am_select == $past(reg_wdata[0]))
      else $error("first carrier mode field wrong");
   a_ident_run: assert property (
      ident_reset == (ident_speed == 2'h3))
      else $error("ident reset out of step with ident speed");

   // divider residue stays below one reference step, else a tick would be lost
   a_frac_bound: assert property (
      q.frac < REF_CLK_KHZ)
      else $error("mixer divider residue out of range");
   // phase only advances on a mixer tick
   a_phase_hold: assert property (
      !mix_tick |=> $stable(carrier_one_phase) && $stable(carrier_two_phase))
      else $error("phase moved without a mixer tick");
endmodule

// ===== verification/sdcr_ctrl_model.sv
// Purpose: i2c controller stand-in issuing byte writes and read-out pulses
// Assumes: requests change on the falling edge of the clock
// Notes: released address and data lines show the inverse of the last value
module sdcr_ctrl_model
   import sdcr_pkg::*;
(
   // clock
   input wire logic clk,
   // byte write port
   output logic reg_wr,
   output logic [7:0] reg_subaddr,
   output logic [7:0] reg_wdata,
   output logic xfer_end,
   // monitor read-out
   output logic mon_read_done
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle bus from time zero
   initial begin
      reg_wr = 1'b0;
      reg_subaddr = 8'hff;
      reg_wdata = 8'hff;
      xfer_end = 1'b0;
      mon_read_done = 1'b0;
   end

   // one byte; lines flip on release so a stale value never passes
   task automatic write_byte(input logic [7:0] sa, input logic [7:0] b);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_subaddr = sa;
      reg_wdata = b;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_subaddr = ~sa;
      reg_wdata = ~b;
   endtask

   // unused monitor select bits always go out as zero
   task automatic write_monitor(input logic [7:0] b);
      write_byte(SA_MON_SEL, b & 8'h9b);
   endtask

   // three bytes back to back, high first; only with the internal sound path
   task automatic write_word(input logic [7:0] sa, input logic [23:0] w);
      @(negedge clk);
      reg_wr = 1'b1;
      for (int k = 0; k < 3; k++) begin
         reg_subaddr = sa + 8'(k);
         reg_wdata = w[23-8*k -: 8];
         @(negedge clk);
      end
      reg_wr = 1'b0;
      reg_subaddr = ~reg_subaddr;
      reg_wdata = ~reg_wdata;
   endtask

   // stop condition ends the transfer
   task automatic end_transfer();
      @(negedge clk);
      xfer_end = 1'b1;
      @(negedge clk);
      xfer_end = 1'b0;
   endtask

   // read-out; the first one after a source change is thrown away by the caller
   task automatic read_mon();
      @(negedge clk);
      mon_read_done = 1'b1;
      @(negedge clk);
      mon_read_done = 1'b0;
   endtask
endmodule

// ===== verification/tb_sdcr_regs.sv
// Purpose: self-checking bench for the sound demodulator config registers
// Assumes: 40 mhz ref_clk, inputs driven on the falling edge
// Notes: taps follow one offset so every tap input moves during the run
module tb_sdcr_regs
   import sdcr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic samp_valid = 1'b0;
   logic reg_wr, xfer_end, mon_read_done, ident_region, ident_reset, first_am, mix_tick;
   logic [7:0] reg_subaddr, reg_wdata, monitor_select, demod_config;
   logic [1:0] ident_speed, filter_width, second_mode;
   logic [23:0] c1, c2, p1, p2;
   logic [15:0] mon_value;
   logic signed [15:0] o = 16'sh0;
   logic signed [15:0] dc1, dc2, ph1, ph2, mag1, mag2, path1, path2, nicam1, nicam2;
   int mismatches = 0;
   int checked = 0;

   // clock
   always #12.5 ref_clk = ~ref_clk;

   // taps: channel two always ten above channel one
   assign dc1 = o + 16'sd10;
   assign dc2 = o + 16'sd20;
   assign ph1 = o + 16'sd30;
   assign ph2 = o + 16'sd40;
   assign path1 = o + 16'sd50;
   assign path2 = o + 16'sd60;
   assign nicam1 = o + 16'sd70;
   assign nicam2 = o + 16'sd80;
   assign mag1 = o + 16'sd90;
   assign mag2 = o + 16'sd100;

   sdcr_ctrl_model i_sdcr_ctrl_model (.clk(ref_clk), .reg_wr(reg_wr), .reg_subaddr(reg_subaddr),
      .reg_wdata(reg_wdata), .xfer_end(xfer_end), .mon_read_done(mon_read_done));

   sdcr_regs i_sdcr_regs (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr),
      .reg_subaddr(reg_subaddr), .reg_wdata(reg_wdata), .xfer_end(xfer_end),
      .mon_read_done(mon_read_done), .samp_valid(samp_valid), .dc1(dc1), .dc2(dc2),
      .ph1(ph1), .ph2(ph2), .mag1(mag1), .mag2(mag2), .path1(path1), .path2(path2),
      .nicam1(nicam1), .nicam2(nicam2), .monitor_select(monitor_select),
      .demod_config(demod_config), .ident_speed(ident_speed), .ident_region(ident_region),
      .ident_reset(ident_reset), .filter_width(filter_width), .second_carrier_mode(second_mode),
      .first_carrier_am_select(first_am), .mix_tick(mix_tick), .carrier_one_freq(c1),
      .carrier_two_freq(c2), .carrier_one_phase(p1), .carrier_two_phase(p2),
      .mon_value(mon_value));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // one sample pulse, then a cycle for the result to land
   task automatic sample(input logic signed [15:0] v);
      @(negedge ref_clk);
      o = v;
      samp_valid = 1'b1;
      @(negedge ref_clk);
      samp_valid = 1'b0;
      cyc(1);
   endtask

   // main sequence
   initial begin
      logic [7:0] v;
      logic [23:0] q1, q2;
      int n, t1;
      cyc(6);
      resetn = 1'b1;
      cyc(4);
      check(monitor_select, MON_SEL_RESET);
      check(demod_config, DCONF_RESET);
      check(c1, FREQ_RESET);
      $display("test reset done");
      // staged bytes stay invisible until the low byte
      i_sdcr_ctrl_model.write_byte(SA_C1_HI, 8'h72);
      i_sdcr_ctrl_model.write_byte(SA_C1_HI + 8'h01, 8'h95);
      cyc(2);
      check(c1, 24'h000000);
      i_sdcr_ctrl_model.write_byte(SA_C1_LO, 8'h55);
      cyc(1);
      check(c1, 24'h729555);
      i_sdcr_ctrl_model.write_word(SA_C2_HI, 24'h123456);
      cyc(1);
      check(c2, 24'h123456);
      check(c1, 24'h729555);
      // early stop drops the staged bytes
      i_sdcr_ctrl_model.write_byte(SA_C2_HI, 8'hab);
      i_sdcr_ctrl_model.write_byte(SA_C2_HI + 8'h01, 8'hcd);
      i_sdcr_ctrl_model.end_transfer();
      i_sdcr_ctrl_model.write_byte(SA_C2_LO, 8'hef);
      i_sdcr_ctrl_model.write_byte(8'h0a, 8'hff);
      cyc(1);
      check(c2, 24'h123456);
      check(demod_config, DCONF_RESET);
      $display("test frequency words done");
      // tick rate over 10000 cycles, one tick of jitter allowed
      n = 0;
      t1 = 10000 * int'(MIX_CLK_KHZ) / int'(REF_CLK_KHZ);
      repeat (10000) begin
         @(negedge ref_clk);
         if (mix_tick === 1'b1) n++;
      end
      check(32'(n >= t1 - 1 && n <= t1 + 1), 32'd1);
      n = 0;
      while (mix_tick !== 1'b1 && n < 8) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 8) begin
         mismatches++;
         summarize();
      end
      q1 = p1;
      q2 = p2;
      @(negedge ref_clk);
      check(p1, 24'(q1 + c1));
      check(p2, 24'(q2 + c2));
      $display("test mixer done");
      // every code of every config field
      for (int i = 0; i < 4; i++) begin
         v = 8'h55 * 8'(i);
         i_sdcr_ctrl_model.write_byte(SA_DCONF, v);
         cyc(1);
         check(demod_config, v);
         check(ident_speed, v[7:6]);
         check(ident_reset, v[7] & v[6]);
         check(ident_region, v[5]);
         check(filter_width, {v[4], v[1]});
         check(second_mode, v[3:2]);
         check(first_am, v[0]);
      end
      $display("test demod config done");
      // every source and channel, in fm and in am mode
      for (int a = 0; a < 2; a++) begin
         i_sdcr_ctrl_model.write_byte(SA_DCONF, (a == 1) ? 8'h05 : 8'h00);
         for (int s = 0; s < 4; s++) begin
            for (int c = 0; c < 3; c++) begin
               v = {3'b000, 2'(c), 1'b0, 2'(s)};
               i_sdcr_ctrl_model.write_monitor(v);
               sample(16'(7 * s + c));
               t1 = 7 * s + c + 10 + 20 * s + ((s == 1 && a == 1) ? 60 : 0);
               check(monitor_select, v);
               check(mon_value, 32'(t1 + ((c == 0) ? 5 : 10 * (c - 1))));
            end
         end
      end
      $display("test monitor taps done");
      // peak capture, cleared by read-out
      i_sdcr_ctrl_model.write_byte(SA_DCONF, 8'h00);
      i_sdcr_ctrl_model.write_monitor(8'h88);
      sample(-16'sd40);
      i_sdcr_ctrl_model.read_mon();
      sample(-16'sd40);
      sample(16'sd2);
      check(mon_value, 32'd30);
      i_sdcr_ctrl_model.read_mon();
      cyc(1);
      check(mon_value, 32'd0);
      sample(-16'sd3);
      check(mon_value, 32'd7);
      $display("test peak done");
      summarize();
   end
endmodule
